//--- rtl/r15_operand_and_multiply_unit.sv
// Summary of operation
// - PC destination without flag bit writes only the 24 PC bits.
// - Test ops with PC destination and flag bit update unprotected flags.
// - Other destinations update condition flags from ALU flags by class.
// - PC destination with flag bit overwrites status from result bits.
// - Bits 31:28 to NZCV; outside user mode 27,26,1,0 to I,F,mode.
// - Status-load test replaces NZCV from its operands; I, F, mode only outside user mode.
// - PC as second operand gives PC with status to the shifter.
// - PC as first or shift operand gives PC with status zeroed.
// - PC reads plus 8, or plus 12 as first or second operand with register shift.
// - Radix-4 Booth multiply of 32-bit operands, low 32 bits kept.
// - Plain multiply writes second operand times multiplier, no accumulate.
// - Accumulate form adds the accumulate register to the product.
// - Same low result for signed and unsigned operands.
// - Destination equal to second operand: the product term is zero.
// - Multiply to PC writes no register; flags may be scrambled.
// - All other register combinations give a correct product.
// - Multiply flags: N bit 31, Z on zero, V kept, C meaningless.
// - PC multiply operands: plier +8 bare, acc +8, second +12 w/status.
//
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
`include "r15_mul_defs.svh"
`default_nettype none
module r15_operand_and_multiply_unit (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [31:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic reg_wr_en,
   output logic [3:0] reg_wr_addr,
   output logic [31:0] reg_wr_data
);
   r15_mul_pkg::state_t state;
   r15_mul_pkg::alu_op_t op;
   logic [23:0] cmd;
   logic go;
   logic [31:0] op_a, op_b, op_s, processor_status_word, result;
   logic [23:0] pc;
   logic wrote_reg, wrote_pc;
   logic [31:0] mcand, macc;
   logic [32:0] mplier;
   logic [3:0] count;
   logic [31:0] next_psr;
   logic [23:0] next_pc;
   logic [31:0] ax, ay, logic_res;
   logic cin, arith;
   logic [31:0] chk_expect;

   function automatic logic [31:0] merge(input logic [31:0] old,
         input logic [31:0] nw, input logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (st[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : merge

   // bus decode; the slave waits for address and data together
   wire aw_take = awready & awvalid & wvalid;
   wire ar_take = arready & arvalid;
   wire hit_cmd = awaddr == `OFS_CMD;
   wire hit_first = awaddr == `OFS_FIRST;
   wire hit_second = awaddr == `OFS_SECOND;
   wire hit_shift = awaddr == `OFS_SHIFT_MUL;
   wire hit_pc = awaddr == `OFS_PC;
   wire hit_psr = awaddr == `OFS_PSR;
   wire w_known = hit_cmd | hit_first | hit_second | hit_shift | hit_pc
      | hit_psr;
   wire busy = go | (state == r15_mul_pkg::st_mul);
   // command writes while busy are dropped: no queue behind the multiplier
   wire cmd_write = aw_take & hit_cmd & (wstrb == 4'hf) & ~busy;

   // command fields
   assign op = r15_mul_pkg::alu_op_t'(cmd[`F_OP]);
   wire s_bit = cmd[`F_S];
   wire is_mul = cmd[`F_MUL];
   wire is_acc = cmd[`F_ACC];
   wire reg_shift = cmd[`F_REGSH];
   wire [3:0] rd = cmd[`F_RD];
   wire rd_pc = rd == `PC_INDEX;
   wire rn_pc = cmd[`F_RN] == `PC_INDEX;
   wire rm_pc = cmd[`F_RM] == `PC_INDEX;
   wire rs_pc = cmd[`F_RS] == `PC_INDEX;
   wire rd_eq_rm = rd == cmd[`F_RM];
   wire is_test = op[3:2] == 2'h2;
   wire user_mode = processor_status_word[`F_MODE] == `MODE_USER;

   // program counter views, prefetch offsets
   wire [23:0] pc8 = pc + `PC_STEP8;
   wire [23:0] pc12 = pc + `PC_STEP12;
   wire [31:0] pc8_bare = {6'h00, pc8, 2'h0};
   wire [31:0] pc12_bare = {6'h00, pc12, 2'h0};
   wire [31:0] pc8_stat = {processor_status_word[31:26], pc8, processor_status_word[`F_MODE]};
   wire [31:0] pc12_stat = {processor_status_word[31:26], pc12, processor_status_word[`F_MODE]};

   // operand selection
   wire [31:0] dp_a = rn_pc ? (reg_shift ? pc12_bare : pc8_bare) : op_a;
   wire [31:0] dp_b = rm_pc ? (reg_shift ? pc12_stat : pc8_stat) : op_b;
   wire [31:0] sh_amt = rs_pc ? pc8_bare : op_s;
   wire [31:0] mul_acc = rn_pc ? pc8_stat : op_a;
   wire [31:0] mul_cand = rm_pc ? pc12_stat : op_b;
   wire [31:0] mul_plier = rs_pc ? pc8_bare : op_s;
   // intermediates overwrite the destination, which kills the multiplicand
   wire [31:0] cand_eff = rd_eq_rm ? 32'h0 : mul_cand;
   wire [31:0] acc_eff = is_acc ? mul_acc : 32'h0;

   // alu; the shifter is outside, op2 arrives as LSL 0
   always_comb begin
      ax = dp_a;
      ay = dp_b;
      cin = 1'b0;
      arith = 1'b1;
      logic_res = 32'h0;
      unique case (op)
         r15_mul_pkg::logic_and_op, r15_mul_pkg::test_and_op: begin
            arith = 1'b0;
            logic_res = dp_a & dp_b;
         end
         r15_mul_pkg::logic_xor_op, r15_mul_pkg::test_xor_op: begin
            arith = 1'b0;
            logic_res = dp_a ^ dp_b;
         end
         r15_mul_pkg::logic_or_op: begin
            arith = 1'b0;
            logic_res = dp_a | dp_b;
         end
         r15_mul_pkg::move_op: begin
            arith = 1'b0;
            logic_res = dp_b;
         end
         r15_mul_pkg::bit_clear_op: begin
            arith = 1'b0;
            logic_res = dp_a & ~dp_b;
         end
         r15_mul_pkg::move_not_op: begin
            arith = 1'b0;
            logic_res = ~dp_b;
         end
         r15_mul_pkg::sub_op, r15_mul_pkg::compare_subtract_op: begin
            ay = ~dp_b;
            cin = 1'b1;
         end
         r15_mul_pkg::rev_sub_op: begin
            ax = dp_b;
            ay = ~dp_a;
            cin = 1'b1;
         end
         r15_mul_pkg::add_op, r15_mul_pkg::compare_add_op: begin
            cin = 1'b0;
         end
         r15_mul_pkg::add_carry_op: begin
            cin = processor_status_word[`F_C];
         end
         r15_mul_pkg::sub_carry_op: begin
            ay = ~dp_b;
            cin = processor_status_word[`F_C];
         end
         r15_mul_pkg::rev_sub_carry_op: begin
            ax = dp_b;
            ay = ~dp_a;
            cin = processor_status_word[`F_C];
         end
      endcase
   end

   wire [32:0] sum = {1'b0, ax} + {1'b0, ay} + {32'h0, cin};
   wire ovf = (ax[31] == ay[31]) & (sum[31] != ax[31]);
   wire [31:0] alu_res = arith ? sum[31:0] : logic_res;
   // logical class keeps C as the shifter carry of LSL 0, and keeps V
   wire alu_c = arith ? sum[32] : processor_status_word[`F_C];
   wire alu_v = arith ? ovf : processor_status_word[`F_V];

   // radix-4 booth step
   wire [2:0] bt = mplier[2:0];
   wire [31:0] cand2 = {mcand[30:0], 1'b0};
   wire [31:0] pp = (bt == 3'h1 || bt == 3'h2) ? mcand :
                    (bt == 3'h3) ? cand2 :
                    (bt == 3'h4) ? -cand2 :
                    (bt == 3'h5 || bt == 3'h6) ? -mcand : 32'h0;
   wire [31:0] mul_final = macc + pp;

   wire idle = state == r15_mul_pkg::st_idle;
   wire dp_go = go & idle & ~is_mul;
   wire mul_start = go & idle & is_mul;
   wire mul_commit = (state == r15_mul_pkg::st_mul) & (count == `MUL_LAST);

   // status word update
   always_comb begin
      next_psr = processor_status_word;
      if (aw_take & hit_psr) begin
         next_psr = merge(processor_status_word, wdata, wstrb) & `PSR_MASK;
      end
      if (dp_go & s_bit) begin
         if (rd_pc) begin
            next_psr[`F_FLAGS] = alu_res[`F_FLAGS];
            if (!user_mode) begin
               next_psr[`F_I] = alu_res[`F_I];
               next_psr[`F_F] = alu_res[`F_F];
               next_psr[`F_MODE] = alu_res[`F_MODE];
            end
         end else begin
            next_psr[`F_FLAGS] = {alu_res[31], alu_res == 32'h0, alu_c,
               alu_v};
         end
      end
      if (mul_commit & s_bit) begin
         // carry is meaningless here; zero is as good as any value
         next_psr[`F_N] = mul_final[31];
         next_psr[`F_Z] = mul_final == 32'h0;
         next_psr[`F_C] = 1'b0;
      end
   end

   wire [31:0] pc_bus = merge({6'h00, pc, 2'h0}, wdata, wstrb);
   always_comb begin
      next_pc = pc;
      if (aw_take & hit_pc) begin
         next_pc = pc_bus[`F_PC];
      end
      if (dp_go & rd_pc & ~is_test) begin
         next_pc = alu_res[`F_PC];
      end
   end

   wire [31:0] status_word = {29'h0, wrote_pc, wrote_reg, busy};
   wire [31:0] rd_mux =
      (araddr == `OFS_CMD) ? {8'h00, cmd} :
      (araddr == `OFS_FIRST) ? op_a :
      (araddr == `OFS_SECOND) ? op_b :
      (araddr == `OFS_SHIFT_MUL) ? op_s :
      (araddr == `OFS_PC) ? {6'h00, pc, 2'h0} :
      (araddr == `OFS_PSR) ? processor_status_word :
      (araddr == `OFS_RESULT) ? result :
      (araddr == `OFS_STATUS) ? status_word :
      (araddr == `OFS_SHAMT) ? sh_amt : 32'h0;
   wire r_known = araddr <= `OFS_SHAMT && araddr[1:0] == 2'h0;

   // bus slave
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= `RESP_OKAY;
      end else begin
         awready <= ~awready & awvalid & wvalid & ~bvalid;
         wready <= ~wready & awvalid & wvalid & ~bvalid;
         if (aw_take) begin
            bvalid <= 1'b1;
            bresp <= w_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= `RESP_OKAY;
      end else begin
         arready <= ~arready & arvalid & ~rvalid;
         if (ar_take) begin
            rvalid <= 1'b1;
            rdata <= rd_mux;
            rresp <= r_known ? `RESP_OKAY : `RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // software-visible registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd <= 24'h0;
         op_a <= 32'h0;
         op_b <= 32'h0;
         op_s <= 32'h0;
         pc <= `PC_RESET;
         processor_status_word <= `PSR_RESET;
      end else begin
         if (cmd_write) cmd <= wdata[23:0];
         if (aw_take & hit_first) op_a <= merge(op_a, wdata, wstrb);
         if (aw_take & hit_second) op_b <= merge(op_b, wdata, wstrb);
         if (aw_take & hit_shift) op_s <= merge(op_s, wdata, wstrb);
         pc <= next_pc;
         processor_status_word <= next_psr;
      end
   end

   // sequencer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= r15_mul_pkg::st_idle;
         go <= 1'b0;
         count <= 4'h0;
      end else begin
         go <= cmd_write | (go & ~idle);
         unique case (state)
            r15_mul_pkg::st_idle: begin
               count <= 4'h0;
               if (mul_start) state <= r15_mul_pkg::st_mul;
            end
            r15_mul_pkg::st_mul: begin
               count <= count + 4'h1;
               if (mul_commit) state <= r15_mul_pkg::st_idle;
            end
         endcase
      end
   end

   // booth iteration, two multiplier bits per cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mcand <= 32'h0;
         mplier <= 33'h0;
         macc <= 32'h0;
         chk_expect <= 32'h0;
      end else if (mul_start) begin
         mcand <= cand_eff;
         mplier <= {mul_plier, 1'b0};
         macc <= acc_eff;
         chk_expect <= 32'(cand_eff * mul_plier) + acc_eff;
      end else if (state == r15_mul_pkg::st_mul) begin
         mcand <= {mcand[29:0], 2'h0};
         mplier <= {{2{mplier[32]}}, mplier[32:2]};
         macc <= mul_final;
      end
   end

   // result port toward the register bank
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         reg_wr_en <= 1'b0;
         reg_wr_addr <= 4'h0;
         reg_wr_data <= 32'h0;
         result <= 32'h0;
         wrote_reg <= 1'b0;
         wrote_pc <= 1'b0;
      end else begin
         reg_wr_en <= (dp_go & ~rd_pc & ~is_test) | (mul_commit & ~rd_pc);
         reg_wr_addr <= rd;
         reg_wr_data <= dp_go ? alu_res : mul_final;
         if (dp_go) begin
            result <= alu_res;
            wrote_reg <= ~rd_pc & ~is_test;
            wrote_pc <= rd_pc & ~is_test;
         end else if (mul_commit) begin
            result <= mul_final;
            wrote_reg <= ~rd_pc;
            wrote_pc <= 1'b0;
         end
      end
   end

   a_pc_bits_only: assert property (
      @(posedge aclk) disable iff (!aresetn)
      dp_go && rd_pc && !s_bit |=> $stable(processor_status_word))
      else $error("status changed on plain pc write");

   a_psr_overwrite: assert property (
      @(posedge aclk) disable iff (!aresetn)
      dp_go && rd_pc && s_bit |=> processor_status_word[31:28] == $past(alu_res[31:28]))
      else $error("flags not taken from result bits");

   a_user_protect: assert property (
      @(posedge aclk) disable iff (!aresetn)
      dp_go && rd_pc && s_bit && user_mode && !(aw_take && hit_psr)
      |=> $stable(processor_status_word[27:0]))
      else $error("protected status bits changed in user mode");

   a_alu_zero_flag: assert property (
      @(posedge aclk) disable iff (!aresetn)
      dp_go && !rd_pc && s_bit
      |=> processor_status_word[30] == ($past(alu_res) == 32'h0) && !reg_wr_en == $past(is_test))
      else $error("zero flag or write enable wrong");

   a_mul_latency: assert property (
      @(posedge aclk) disable iff (!aresetn)
      mul_start && !rd_pc |-> busy [*8] ##10 reg_wr_en)
      else $error("multiply did not commit after 17 cycles");

   a_booth_product: assert property (
      @(posedge aclk) disable iff (!aresetn)
      mul_commit |=> result == chk_expect)
      else $error("booth product mismatch");

   a_mul_pc_dest: assert property (
      @(posedge aclk) disable iff (!aresetn)
      mul_commit && rd_pc |=> !reg_wr_en)
      else $error("multiply wrote a register with pc destination");

   a_mul_keeps_v: assert property (
      @(posedge aclk) disable iff (!aresetn)
      mul_commit && s_bit |=> $stable(processor_status_word[28])
      && processor_status_word[31] == result[31])
      else $error("multiply flags wrong");

   a_pc_first_bare: assert property (
      @(posedge aclk) disable iff (!aresetn)
      dp_go && rn_pc |-> dp_a[31:26] == 6'h00 && dp_a[1:0] == 2'h0
      && sh_amt[31:26] == (rs_pc ? 6'h00 : op_s[31:26]))
      else $error("pc operand view wrong");
endmodule : r15_operand_and_multiply_unit
`default_nettype wire

//--- rtl/r15_mul_defs.svh
`ifndef R15_MUL_DEFS_SVH
`define R15_MUL_DEFS_SVH

// register byte offsets
`define OFS_CMD 32'h0000_0000
`define OFS_FIRST 32'h0000_0004
`define OFS_SECOND 32'h0000_0008
`define OFS_SHIFT_MUL 32'h0000_000c
`define OFS_PC 32'h0000_0010
`define OFS_PSR 32'h0000_0014
`define OFS_RESULT 32'h0000_0018
`define OFS_STATUS 32'h0000_001c
`define OFS_SHAMT 32'h0000_0020

// command word fields
`define F_OP 3:0
`define F_S 4
`define F_MUL 5
`define F_ACC 6
`define F_REGSH 7
`define F_RD 11:8
`define F_RN 15:12
`define F_RM 19:16
`define F_RS 23:20

// status word fields
`define F_FLAGS 31:28
`define F_N 31
`define F_Z 30
`define F_C 29
`define F_V 28
`define F_I 27
`define F_F 26
`define F_PC 25:2
`define F_MODE 1:0

// reset values and constants
`define PSR_RESET 32'h0c00_0003
`define PSR_MASK 32'hfc00_0003
`define PC_RESET 24'h00_0000
`define PC_STEP8 24'h00_0002
`define PC_STEP12 24'h00_0003
`define PC_INDEX 4'hf
`define MODE_USER 2'h0
`define MUL_LAST 4'hf
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- rtl/r15_mul_pkg.sv
`default_nettype none
package r15_mul_pkg;
   typedef enum logic [1:0] {
      st_idle = 2'h1,
      st_mul = 2'h2
   } state_t;

   typedef enum logic [3:0] {
      logic_and_op = 4'h0,
      logic_xor_op = 4'h1,
      sub_op = 4'h2,
      rev_sub_op = 4'h3,
      add_op = 4'h4,
      add_carry_op = 4'h5,
      sub_carry_op = 4'h6,
      rev_sub_carry_op = 4'h7,
      test_and_op = 4'h8,
      test_xor_op = 4'h9,
      compare_subtract_op = 4'ha,
      compare_add_op = 4'hb,
      logic_or_op = 4'hc,
      move_op = 4'hd,
      bit_clear_op = 4'he,
      move_not_op = 4'hf
   } alu_op_t;
endpackage : r15_mul_pkg
`default_nettype wire

//--- rtl/dummy_unused_never.sv
`default_nettype none
`default_nettype wire

//--- bench/reg_bank_model.sv
`default_nettype none
// register bank side: records every write the unit commits
module reg_bank_model (
   input wire logic aclk,
   input wire logic reg_wr_en,
   input wire logic [3:0] reg_wr_addr,
   input wire logic [31:0] reg_wr_data,
   output logic [3:0] last_addr,
   output logic [31:0] last_data,
   output int writes
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      last_addr = 4'h0;
      last_data = 32'h0;
      writes = 0;
   end
   // unknown enable counts as no write, so a stray x cannot look clean
   always @(posedge aclk) begin
      if (reg_wr_en === 1'b1) begin
         last_addr <= reg_wr_addr;
         last_data <= reg_wr_data;
         writes <= writes + 1;
      end
   end
endmodule : reg_bank_model
`default_nettype wire

//--- bench/tb_top.sv
`include "r15_mul_defs.svh"
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] op_mov = r15_mul_pkg::move_op;
   localparam logic [3:0] op_add = r15_mul_pkg::add_op;
   localparam logic [3:0] op_and = r15_mul_pkg::logic_and_op;
   localparam logic [3:0] op_teq = r15_mul_pkg::test_xor_op;
   localparam logic [3:0] tops [4] = '{4'h8, 4'h9, 4'ha, 4'hb};
   localparam logic [31:0] texp [4] = '{32'h20000000, 32'h40000000,
      32'h40000000, 32'h80000000};
   localparam logic [3:0] aops [9] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7,
      4'hc, 4'he, 4'hf};
   localparam logic [31:0] aexp [9] = '{32'h40000000, 32'h40000000,
      32'hc0000000, 32'h80000001, 32'h40000000, 32'hc0000000, 32'h60000000,
      32'h40000000, 32'hdfffffff};
   localparam logic [31:0] ma [4] = '{32'h7, 32'hfffffffd, 32'h12345678,
      32'h9};
   localparam logic [31:0] mb [4] = '{32'h6, 32'h5, 32'h9abcdef1, 32'h3};
   localparam logic [31:0] mc [4] = '{32'h55, 32'h0, 32'h11, 32'h4};
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [31:0] awaddr = 32'h0;
   logic [31:0] wdata = 32'h0;
   logic [31:0] araddr = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, reg_wr_en;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, reg_wr_data, last_data;
   logic [3:0] reg_wr_addr, last_addr;
   int writes;
   int num_errors = 0;
   int checks = 0;
   always #4 aclk = ~aclk;
   r15_operand_and_multiply_unit u_dut (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data)
   );
   reg_bank_model u_bank (
      .aclk(aclk), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
      .reg_wr_data(reg_wr_data), .last_addr(last_addr),
      .last_data(last_data), .writes(writes)
   );
   task automatic results;
      $display("mismatches %0d comparisons %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : results
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
         input string what);
      checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk
   task automatic tmo(input int n);
      if (n >= 200) begin
         num_errors++;
         $display("Error handshake wait expired");
         results();
      end
   endtask : tmo
   task automatic axw(input logic [31:0] a, input logic [31:0] d,
         output logic [1:0] r);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
         n++;
      end while (bvalid !== 1'b1 && n < 200);
      r = bresp;
      bready <= 1'b0;
      tmo(n);
   endtask : axw
   task automatic axr(input logic [31:0] a, output logic [31:0] d,
         output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
      end while (rvalid !== 1'b1 && n < 200);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      tmo(n);
   endtask : axr
   task automatic wr(input logic [31:0] a, input logic [31:0] d,
         input logic [1:0] er = 2'h0);
      logic [1:0] r;
      axw(a, d, r);
      chk({30'h0, r}, {30'h0, er}, $sformatf("write response %h", a));
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] exp,
         input logic [31:0] m = 32'hffffffff, input logic [1:0] er = 2'h0);
      logic [31:0] d;
      logic [1:0] r;
      axr(a, d, r);
      chk(d & m, exp, $sformatf("read data %h", a));
      chk({30'h0, r}, {30'h0, er}, $sformatf("read response %h", a));
   endtask : rd
   // first status sample tells whether the unit was still busy with the command
   task automatic run(input logic [31:0] c, output logic busy0);
      logic [31:0] s;
      logic [1:0] r;
      int n;
      wr(`OFS_CMD, c);
      axr(`OFS_STATUS, s, r);
      busy0 = s[0];
      n = 0;
      while (s[0] !== 1'b0 && n < 200) begin
         axr(`OFS_STATUS, s, r);
         n++;
      end
      tmo(n);
   endtask : run
   function automatic logic [31:0] cmd(input logic [3:0] op, input logic s,
         input logic m, input logic ac, input logic rsh, input logic [3:0] d,
         input logic [3:0] n, input logic [3:0] mm, input logic [3:0] rs);
      return {8'h00, rs, mm, n, d, rsh, ac, m, s, op};
   endfunction : cmd
   initial begin
      logic b;
      logic [31:0] e;
      int cnt;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`OFS_PSR, `PSR_RESET);
      rd(`OFS_PC, 32'h0);
      rd(32'h24, 32'h0, 32'hffffffff, `RESP_SLVERR);
      wr(32'h24, 32'h1, `RESP_SLVERR);
      // rd, rn and rs share one index on purpose
      for (int i = 0; i < 4; i++) begin
         wr(`OFS_SECOND, ma[i]);
         wr(`OFS_SHIFT_MUL, mb[i]);
         wr(`OFS_FIRST, mc[i]);
         run(cmd(op_add, 1'b0, 1'b1, i[1], 1'b0, 4'h4, 4'h4, 4'h2, 4'h4), b);
         e = ma[i] * mb[i] + (i[1] ? mc[i] : 32'h0);
         chk({31'h0, b}, 32'h1, "busy after start");
         rd(`OFS_RESULT, e);
         chk(last_data, e, "bank data");
         chk({28'h0, last_addr}, 32'h4, "bank index");
      end
      wr(`OFS_PSR, 32'h3c000003);
      wr(`OFS_SECOND, 32'h80000000);
      wr(`OFS_SHIFT_MUL, 32'h1);
      run(cmd(4'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 4'h0, 4'h2, 4'h3), b);
      rd(`OFS_PSR, 32'h90000000, 32'hd0000000);
      wr(`OFS_SECOND, 32'h0);
      run(cmd(4'h0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 4'h0, 4'h2, 4'h3), b);
      rd(`OFS_PSR, 32'h50000000, 32'hd0000000);
      wr(`OFS_SECOND, 32'h80000000);
      run(cmd(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h1, 4'h0, 4'h2, 4'h3), b);
      rd(`OFS_PSR, 32'h50000000, 32'hd0000000);
      wr(`OFS_SECOND, 32'h5);
      run(cmd(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h2, 4'h0, 4'h2, 4'h3), b);
      rd(`OFS_RESULT, 32'h0);
      chk(last_data, 32'h0, "bank data");
      wr(`OFS_PC, 32'h100);
      cnt = writes;
      run(cmd(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'hf, 4'h0, 4'h2, 4'h3), b);
      chk(writes, cnt, "bank writes");
      rd(`OFS_STATUS, 32'h0, 32'h6);
      rd(`OFS_PC, 32'h100);
      // pc operand views: +8 or +12 bare, +8 or +12 with status
      wr(`OFS_PSR, 32'hac000003);
      wr(`OFS_SECOND, 32'h2);
      run(cmd(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h3, 4'h0, 4'h2, 4'hf), b);
      chk(last_data, 32'h210, "mul pc multiplier");
      wr(`OFS_SHIFT_MUL, 32'h1);
      run(cmd(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 4'h3, 4'h0, 4'hf, 4'h1), b);
      chk(last_data, 32'hac00010f, "mul pc second");
      wr(`OFS_SECOND, 32'h0);
      run(cmd(4'h0, 1'b0, 1'b1, 1'b1, 1'b0, 4'h3, 4'hf, 4'h2, 4'h1), b);
      chk(last_data, 32'hac00010b, "mul pc accumulate");
      run(cmd(op_mov, 1'b0, 1'b0, 1'b0, 1'b0, 4'h5, 4'h0, 4'hf, 4'h1), b);
      chk(last_data, 32'hac00010b, "pc second imm");
      run(cmd(op_mov, 1'b0, 1'b0, 1'b0, 1'b1, 4'h5, 4'h0, 4'hf, 4'hf), b);
      chk(last_data, 32'hac00010f, "pc second reg");
      rd(`OFS_SHAMT, 32'h108);
      run(cmd(op_add, 1'b0, 1'b0, 1'b0, 1'b0, 4'h5, 4'hf, 4'h2, 4'h1), b);
      chk(last_data, 32'h108, "pc first imm");
      run(cmd(op_add, 1'b0, 1'b0, 1'b0, 1'b1, 4'h5, 4'hf, 4'h2, 4'h1), b);
      chk(last_data, 32'h10c, "pc first reg");
      wr(`OFS_PSR, `PSR_RESET);
      wr(`OFS_FIRST, 32'h7fffffff);
      wr(`OFS_SECOND, 32'h1);
      run(cmd(op_add, 1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 4'h0, 4'h2, 4'h0), b);
      chk(last_data, 32'h80000000, "add result");
      rd(`OFS_PSR, 32'h9c000003);
      wr(`OFS_PSR, 32'h3c000003);
      wr(`OFS_FIRST, 32'hf0000000);
      wr(`OFS_SECOND, 32'h80000000);
      run(cmd(op_and, 1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 4'h0, 4'h2, 4'h0), b);
      rd(`OFS_PSR, 32'hbc000003);
      wr(`OFS_SECOND, 32'hf0000104);
      run(cmd(op_mov, 1'b0, 1'b0, 1'b0, 1'b0, 4'hf, 4'h0, 4'h2, 4'h0), b);
      rd(`OFS_PC, 32'h104);
      rd(`OFS_PSR, 32'hbc000003);
      wr(`OFS_SECOND, 32'hf0000002);
      run(cmd(op_mov, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf, 4'h0, 4'h2, 4'h0), b);
      rd(`OFS_PSR, 32'hf0000002);
      wr(`OFS_SECOND, 32'h50000000);
      run(cmd(op_mov, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf, 4'h0, 4'h2, 4'h0), b);
      rd(`OFS_PSR, 32'h50000000);
      // now in user mode: the next command names no banked index
      wr(`OFS_SECOND, 32'hffffffff);
      run(cmd(op_mov, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf, 4'h0, 4'h2, 4'h0), b);
      rd(`OFS_PSR, 32'hf0000000);
      wr(`OFS_FIRST, 32'h60000000);
      wr(`OFS_SECOND, 32'h20000000);
      // remaining opcodes, carry set from the last status load
      for (int i = 0; i < 9; i++) begin
         run(cmd(aops[i], 1'b0, 1'b0, 1'b0, 1'b0, 4'h1, 4'h0, 4'h2, 4'h0), b);
         chk(last_data, aexp[i], "alu opcode result");
      end
      for (int i = 0; i < 4; i++) begin
         run(cmd(tops[i], 1'b1, 1'b0, 1'b0, 1'b0, 4'hf, 4'h0, 4'h2, 4'h0), b);
         rd(`OFS_PSR, texp[i]);
      end
      wr(`OFS_PSR, `PSR_RESET);
      wr(`OFS_PC, 32'h0);
      wr(`OFS_SECOND, 32'hc8000001);
      run(cmd(op_teq, 1'b1, 1'b0, 1'b0, 1'b0, 4'hf, 4'hf, 4'h2, 4'h0), b);
      rd(`OFS_PSR, 32'hc8000001);
      results();
   end
endmodule : tb_top
`default_nettype wire
